// *** sim/cser_chk_sva.sv ***
// assertions on the scrub error report pins
`timescale 1ns/100ps
`default_nettype none
`include "cser_regs.vh"
module cser_chk
(
   // clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // pins in
   input wire logic user_mode_pin,
   input wire logic crc_check_valid,
   input wire logic crc_check_ok,
   input wire logic ecc_valid,
   input wire logic [1:0] ecc_kind,
   input wire logic [`CSER_FRAME_W-1:0] ecc_frame,
   input wire logic [`CSER_CLUS_W-1:0] ecc_cluster,
   input wire logic [`CSER_BLK_W-1:0] ecc_block,
   // pins out
   input wire logic bitstream_accept,
   input wire logic scrub_run,
   input wire logic ecc_correct,
   input wire logic err_single_ff,
   input wire logic err_multi_ff,
   input wire logic [`CSER_FRAME_W-1:0] err_frame_ff,
   input wire logic [`CSER_CLUS_W-1:0] err_cluster_ff,
   input wire logic [`CSER_BLK_W-1:0] err_block_ff,
   input wire logic [`CSER_BIT_W-1:0] err_bit_ff
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   // clean flags followed by a dual report
   sequence s_dual_first;
      !err_single_ff && !err_multi_ff ##1 err_multi_ff;
   endsequence
   run_needs_user_a: assert property (!user_mode_pin [*4] |-> !scrub_run)
      else $error("scrub ran outside user mode");
   single_cause_a: assert property ($rose(err_single_ff) |-> $past(ecc_valid && scrub_run && ecc_kind == `CSER_ERR_SINGLE))
      else $error("single flag without a single report");
   single_loc_a: assert property ($rose(err_single_ff) |-> err_frame_ff == $past(ecc_frame) && err_block_ff == $past(ecc_block)
      && (err_cluster_ff[0] ? err_block_ff <= `CSER_LOGIC_BLK_MAX : err_block_ff == 8'h00))
      else $error("single location wrong");
   dual_report_a: assert property (s_dual_first |-> $past(ecc_valid && ecc_kind == `CSER_ERR_MULTI)
      && err_cluster_ff == $past(ecc_cluster) && err_block_ff == 8'h00 && err_bit_ff == 7'h00)
      else $error("dual report wrong");
   halt_multi_a: assert property ($rose(err_multi_ff) |-> !scrub_run)
      else $error("scrub ran on after dual error");
   correct_single_a: assert property (ecc_correct |-> scrub_run && ecc_valid && ecc_kind == `CSER_ERR_SINGLE)
      else $error("correction not on a single");
   keep_first_a: assert property ((err_single_ff || err_multi_ff) [*2] |-> $stable(err_frame_ff) && $stable(err_cluster_ff))
      else $error("first location overwritten");
   accept_ok_a: assert property (crc_check_valid && crc_check_ok |-> bitstream_accept)
      else $error("good crc refused");
   accept_gate_a: assert property (bitstream_accept |-> crc_check_valid)
      else $error("accept without crc result");
endmodule
bind cser_top cser_chk i_chk (.core_clk, .arst_n, .user_mode_pin, .crc_check_valid, .crc_check_ok, .ecc_valid, .ecc_kind,
   .ecc_frame, .ecc_cluster, .ecc_block, .bitstream_accept, .scrub_run, .ecc_correct, .err_single_ff, .err_multi_ff,
   .err_frame_ff, .err_cluster_ff, .err_block_ff, .err_bit_ff);
`default_nettype wire

// *** sim/cser_mon.sv ***
// fabric-side monitor that drives the scrub select pins
`timescale 1ns/100ps
`default_nettype none
module cser_mon
(
   // requests from the bench
   input wire logic [7:0] want_sel,
   input wire logic want_en,
   // scrub pins
   output logic [7:0] cluster_sel_pin,
   output logic scrub_en_pin,
   input wire logic err_single_ff,
   input wire logic err_multi_ff,
   // location offsets usable only for a single error
   output logic loc_ok
);
   assign cluster_sel_pin = want_sel;
   assign scrub_en_pin = want_en;
   assign loc_ok = err_single_ff && !err_multi_ff;
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
// self-checking bench for the scrub error report block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic core_clk = 0, arst_n = 0, config_reset_n = 1, user_mode_pin = 0, bitstream_load_pin = 0, cor = 0;
   logic crc_check_valid = 0, crc_check_ok = 0, ecc_valid = 0, reg_wr = 0, reg_rd = 0, want_en = 0, loc_ok;
   logic [1:0] ecc_kind = 0;
   logic [23:0] ecc_frame = 0, err_frame_ff;
   logic [7:0] ecc_cluster = 0, ecc_block = 0, want_sel = 0, cluster_sel_pin, err_cluster_ff, err_block_ff;
   logic [6:0] ecc_bit = 0, err_bit_ff;
   logic [3:0] reg_addr = 0;
   logic [31:0] reg_wdata = 0, reg_rdata_ff, seed = 70, f0, f1;
   logic scrub_en_pin, bitstream_accept, scrub_run, ecc_correct, err_single_ff, err_multi_ff, irq;
   int error_cnt = 0, tests_run = 0;
   always #2.5 core_clk = ~core_clk;
   cser_top i_dut (.core_clk, .arst_n, .config_reset_n, .user_mode_pin, .bitstream_load_pin, .crc_check_valid,
      .crc_check_ok, .bitstream_accept, .cluster_sel_pin, .scrub_en_pin, .ecc_valid, .ecc_kind, .ecc_frame,
      .ecc_cluster, .ecc_block, .ecc_bit, .scrub_run, .ecc_correct, .err_single_ff, .err_multi_ff, .err_frame_ff,
      .err_cluster_ff, .err_block_ff, .err_bit_ff, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_ff, .irq);
   cser_mon i_mon (.want_sel, .want_en, .cluster_sel_pin, .scrub_en_pin, .err_single_ff, .err_multi_ff, .loc_ok);
   ////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic w(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      tests_run++;
      if (g !== e)
      begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one-cycle register write
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_wr <= 1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 0;
      #1;
   endtask
   // read, data stands the cycle after the strobe
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge core_clk);
      reg_rd <= 1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 0;
      #1 chk("rdata", e, reg_rdata_ff);
   endtask
   // one checker result pulse, correction sampled while it stands
   task automatic ecc(input logic [1:0] k, input logic [23:0] f, input logic [7:0] c, input logic [7:0] b,
      input logic [6:0] t);
      @(posedge core_clk);
      ecc_valid <= 1;
      ecc_kind <= k;
      ecc_frame <= f;
      ecc_cluster <= c;
      ecc_block <= b;
      ecc_bit <= t;
      #1 cor = ecc_correct;
      @(posedge core_clk);
      ecc_valid <= 0;
      #1;
   endtask
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   initial
   begin
      w(6);
      arst_n <= 1;
      rd(4'h1, 32'h08);
      rd(4'hf, 32'h0);
      @(posedge core_clk);
      crc_check_valid <= 1;
      #1 chk("accept", 0, bitstream_accept);
      wr(4'h0, 32'h4);
      chk("accept", 1, bitstream_accept);
      wr(4'h0, 32'h1);
      crc_check_valid <= 0;
      want_en <= 1;
      want_sel <= 8'h09;
      w(6);
      chk("run", 0, scrub_run);
      wr(4'h0, 32'h3);
      user_mode_pin <= 1;
      w(6);
      chk("run", 0, scrub_run);
      wr(4'h0, 32'h0);
      ecc(1, 24'h508011, 8'h09, 8'h01, 7'h06);
      chk("single", 0, err_single_ff);
      wr(4'h0, 32'h1);
      w(4);
      chk("run", 1, scrub_run);
      ecc(1, 24'h508011, 8'h08, 8'h00, 7'h06);
      ecc(1, 24'h508011, 8'h09, 8'h08, 7'h06);
      chk("single", 0, err_single_ff);
      ecc(1, 24'h508011, 8'h09, 8'h01, 7'h06);
      chk("loc", {1'b1, 24'h508011, 8'h09, 8'h01, 7'h06}, {err_single_ff, err_frame_ff, err_cluster_ff, err_block_ff, err_bit_ff});
      ecc(2, 24'h1, 8'h09, 8'h02, 7'h03);
      chk("multi", 0, err_multi_ff);
      rd(4'h1, 32'h25);
      chk("irq", 0, irq);
      wr(4'h2, 32'h1);
      chk("irq", 1, irq);
      wr(4'h1, 32'h1);
      chk("irq", 0, irq);
      config_reset_n <= 0;
      w(4);
      chk("flags", 0, {err_single_ff, err_multi_ff});
      config_reset_n <= 1;
      rd(4'h5, 32'h0);
      wr(4'h0, 32'h2);
      w(4);
      chk("run", 1, scrub_run);
      f0 = rnd();
      for (int i = 0; i < 5; i++)
      begin
         f1 = rnd();
         ecc(1, f0[23:0], 8'h09, (i == 0) ? 8'h07 : {5'h0, f1[2:0]}, (i == 0) ? 7'h7f : f1[9:3]);
         chk("correct", 2'h3, {cor, scrub_run});
      end
      ecc(2, ~f0[23:0], 8'h09, 8'h01, 7'h01);
      chk("dual", 32'h1000_0000 | f0[23:0], {cor, scrub_run, err_multi_ff, 4'h0, err_frame_ff});
      chk("loc", {8'h09, 8'h07, 7'h7f}, {err_cluster_ff, err_block_ff, err_bit_ff});
      rd(4'h5, 32'h0001_0005);
      bitstream_load_pin <= 1;
      wr(4'h0, 32'h1);
      w(4);
      chk("flags", 0, {err_single_ff, err_multi_ff});
      ecc(2, 24'h508011, 8'h09, 8'h05, 7'h1a);
      chk("dual", {1'b1, 24'h508011, 8'h09, 8'h00, 7'h00}, {err_multi_ff, err_frame_ff, err_cluster_ff, err_block_ff, err_bit_ff});
      chk("locok", 0, loc_ok);
      test_done;
   end
   initial
   begin
      #20000;
      error_cnt++;
      test_done;
   end
endmodule
`default_nettype wire

// *** verilog/cser_regs.vh ***
// constants for the configuration-memory scrub error report block
`ifndef CSER_REGS_VH
`define CSER_REGS_VH
// location field and counter widths
`define CSER_FRAME_W 24
`define CSER_CLUS_W 8
`define CSER_BLK_W 8
`define CSER_BIT_W 7
`define CSER_CNT_W 16
// highest legal offsets
`define CSER_LOGIC_BLK_MAX 8'h07
`define CSER_DELIM_BLK_MAX 8'h00
`define CSER_BIT_MAX 7'h7f
// scrub modes
`define CSER_MODE_OFF 2'h0
`define CSER_MODE_SCAN 2'h1
`define CSER_MODE_REPAIR 2'h2
// control register fields
`define CSER_MODE_W 2
`define CSER_CTRL_BYP 2
// error report kinds from the ecc checker
`define CSER_ERR_NONE 2'h0
`define CSER_ERR_SINGLE 2'h1
`define CSER_ERR_MULTI 2'h2
// register offsets
`define CSER_ADDR_W 4
`define CSER_REG_CTRL 4'h0
`define CSER_REG_STATUS 4'h1
`define CSER_REG_MASK 4'h2
`define CSER_REG_FRAME 4'h3
`define CSER_REG_LOC 4'h4
`define CSER_REG_COUNT 4'h5
// interrupt status bits
`define CSER_IRQ_SINGLE 0
`define CSER_IRQ_MULTI 1
`define CSER_IRQ_CRC 2
`define CSER_IRQ_W 3
`endif

// *** verilog/cser_top.v ***
// configuration-memory scrub error detection, classification and reporting
`timescale 1ns/100ps
`default_nettype none
`include "cser_regs.vh"
// Overview of operation
// - ecc judged per cluster, never across clusters
// - two errors one cluster: dual, no correction
// - different clusters: separate singles, repair mode corrects
// - dual reports frame and cluster; offsets invalid
// - location is frame, cluster, block, bit
// - cluster offset vertical; even delimiter, odd logic
// - logic cluster block offsets zero to seven
// - delimiter cluster only block offset zero
// - bit offset zero to 0x7f always
// - bad bitstream crc rejected unless bypassed
// - detection only in scan or repair mode
// - single error shown on pins after user mode
// - config reset or reload clears holds and counters
// - scrubbing resumes after reset if enabled
// - idle until user mode entered
// - scan mode records first error then halts
// - repair mode runs on past singles, halts on a dual, keeps first location
module cser_top
(
   // clock and reset
   input wire core_clk,
   input wire arst_n,
   // configuration status pins
   input wire config_reset_n,
   input wire user_mode_pin,
   input wire bitstream_load_pin,
   // bitstream crc result from the loader
   input wire crc_check_valid,
   input wire crc_check_ok,
   output wire bitstream_accept,
   // monitor-side pins
   input wire [`CSER_CLUS_W-1:0] cluster_sel_pin,
   input wire scrub_en_pin,
   // ecc checker result for one cluster block
   input wire ecc_valid,
   input wire [1:0] ecc_kind,
   input wire [`CSER_FRAME_W-1:0] ecc_frame,
   input wire [`CSER_CLUS_W-1:0] ecc_cluster,
   input wire [`CSER_BLK_W-1:0] ecc_block,
   input wire [`CSER_BIT_W-1:0] ecc_bit,
   output wire scrub_run,
   output wire ecc_correct,
   // error report pins
   output reg err_single_ff,
   output reg err_multi_ff,
   output reg [`CSER_FRAME_W-1:0] err_frame_ff,
   output reg [`CSER_CLUS_W-1:0] err_cluster_ff,
   output reg [`CSER_BLK_W-1:0] err_block_ff,
   output reg [`CSER_BIT_W-1:0] err_bit_ff,
   // register port
   input wire [`CSER_ADDR_W-1:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [31:0] reg_rdata_ff,
   output wire irq
);
   ////////////////////////////////////////////////////////////////////////
   // state codes, one-hot
   // idle waits for the start conditions, run scrubs, halt holds until a clear
   localparam ST_IDLE = 3'b001;
   localparam ST_RUN = 3'b010;
   localparam ST_HALT = 3'b100;

   // registers
   reg [1:0] user_sync_ff; // user mode synchroniser
   reg [1:0] rst_sync_ff; // config reset synchroniser
   reg [2:0] load_sync_ff; // bitstream load synchroniser plus edge stage
   reg [1:0] en_sync_ff; // scrub enable synchroniser
   reg [2*`CSER_CLUS_W-1:0] sel_sync_ff; // cluster select synchroniser
   reg [2:0] st_ff; // scrub state
   reg [1:0] mode_ff; // scrub mode from software
   reg crc_bypass_ff; // crc bypass from software
   reg [`CSER_IRQ_W-1:0] sts_ff; // sticky event bits
   reg [`CSER_IRQ_W-1:0] mask_ff; // interrupt mask
   reg [`CSER_CNT_W-1:0] cnt_single_ff; // single error count
   reg [`CSER_CNT_W-1:0] cnt_multi_ff; // multiple error count
   reg recorded_ff; // a location is held

   // combinational terms
   wire user_mode; // synchronised user mode level
   wire clear_all; // clears error state, counters and state machine
   wire scrub_en; // synchronised scrub enable
   wire [`CSER_CLUS_W-1:0] cluster_sel; // synchronised cluster select
   wire loc_ok; // reported location lies inside the legal ranges
   wire take; // a checker result that counts this cycle
   wire is_single; // accepted single error
   wire is_multi; // accepted multiple error
   wire crc_fail; // loader reported a crc mismatch without bypass
   wire [`CSER_IRQ_W-1:0] set_bits; // events of this cycle, one per status bit
   wire [`CSER_IRQ_W-1:0] nxt_sts; // status after clear and set
   wire sts_wr; // write aimed at the status register
   wire mode_on; // a scrubbing mode is selected
   genvar gi; // status bit index

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers; logic reads the second stage, and the load edge detector also the third
   // the first stage may go metastable, so nothing else looks at it
   always @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         // flops start low: config reset reads as asserted until synced
         user_sync_ff <= 2'h0;
         rst_sync_ff <= 2'h0;
         load_sync_ff <= 3'h0;
         en_sync_ff <= 2'h0;
         sel_sync_ff <= {2*`CSER_CLUS_W{1'b0}};
      end
      else
      begin
         // every pin moves one stage per edge
         user_sync_ff <= {user_sync_ff[0], user_mode_pin};
         rst_sync_ff <= {rst_sync_ff[0], config_reset_n};
         load_sync_ff <= {load_sync_ff[1:0], bitstream_load_pin};
         en_sync_ff <= {en_sync_ff[0], scrub_en_pin};
         sel_sync_ff <= {sel_sync_ff[`CSER_CLUS_W-1:0], cluster_sel_pin};
      end
   end

   assign user_mode = user_sync_ff[1];
   assign scrub_en = en_sync_ff[1];
   assign cluster_sel = sel_sync_ff[2*`CSER_CLUS_W-1:`CSER_CLUS_W];
   // config reset low or a new bitstream load clears the error state
   // the clear holds for as long as the reset pin stays low
   // the load pin is edge detected so a pin left high clears only once
   assign clear_all = ~rst_sync_ff[1] | (load_sync_ff[1] & ~load_sync_ff[2]);

   ////////////////////////////////////////////////////////////////////////
   // location check: even cluster is delimiter with a single block
   // a single outside the legal ranges names no real cell and is dropped
   assign loc_ok = (ecc_bit <= `CSER_BIT_MAX)
      & (ecc_cluster[0] ? (ecc_block <= `CSER_LOGIC_BLK_MAX)
                        : (ecc_block <= `CSER_DELIM_BLK_MAX));

   // only the two scrubbing codes run; the spare code behaves as off
   assign mode_on = (mode_ff == `CSER_MODE_SCAN) | (mode_ff == `CSER_MODE_REPAIR);
   // the checker reports each cluster on its own, so kind is per cluster
   // cluster_sel trails its pin by two edges; a change counts from then
   assign take = ecc_valid & (st_ff == ST_RUN) & (ecc_cluster == cluster_sel);
   assign is_single = take & (ecc_kind == `CSER_ERR_SINGLE) & loc_ok;
   assign is_multi = take & (ecc_kind == `CSER_ERR_MULTI);
   // correction only for a single error in repair mode, never a dual
   assign ecc_correct = is_single & (mode_ff == `CSER_MODE_REPAIR);
   assign scrub_run = (st_ff == ST_RUN);

   ////////////////////////////////////////////////////////////////////////
   // crc gate on bitstream acceptance
   // the result is a loader strobe; accept is a pure gate on it
   // a failing crc sets its sticky bit even while scrubbing is off
   assign crc_fail = crc_check_valid & ~crc_check_ok & ~crc_bypass_ff;
   assign bitstream_accept = crc_check_valid & (crc_check_ok | crc_bypass_ff);

   ////////////////////////////////////////////////////////////////////////
   // scrub state machine
   always @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         st_ff <= ST_IDLE;
      else if (clear_all)
         // a clear restarts from idle, so scrubbing resumes by itself
         st_ff <= ST_IDLE;
      else
      begin
         case (st_ff)
            ST_IDLE:
            begin
               // wait for user mode, enable pin and an active mode
               if (user_mode & scrub_en & mode_on)
                  st_ff <= ST_RUN;
            end
            ST_RUN:
            begin
               // losing user mode, the enable or the mode drops back to idle
               if (!user_mode || !scrub_en || !mode_on)
                  st_ff <= ST_IDLE;
               // a multiple error halts in either mode
               else if (is_multi)
                  st_ff <= ST_HALT;
               // a single halts scan mode only; repair keeps running
               else if (is_single && mode_ff == `CSER_MODE_SCAN)
                  st_ff <= ST_HALT;
            end
            ST_HALT:
               st_ff <= ST_HALT; // stays halted until a clear
            // an illegal code falls back to idle
            default:
               st_ff <= ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // error flags and first-error location hold
   always @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         // power-up: no error held
         err_single_ff <= 1'b0;
         err_multi_ff <= 1'b0;
         err_frame_ff <= {`CSER_FRAME_W{1'b0}};
         err_cluster_ff <= {`CSER_CLUS_W{1'b0}};
         err_block_ff <= {`CSER_BLK_W{1'b0}};
         err_bit_ff <= {`CSER_BIT_W{1'b0}};
         recorded_ff <= 1'b0;
      end
      else if (clear_all)
      begin
         // a clear wins over a report in the same cycle
         // location and flags share one clear, so no half record is seen
         err_single_ff <= 1'b0;
         err_multi_ff <= 1'b0;
         err_frame_ff <= {`CSER_FRAME_W{1'b0}};
         err_cluster_ff <= {`CSER_CLUS_W{1'b0}};
         err_block_ff <= {`CSER_BLK_W{1'b0}};
         err_bit_ff <= {`CSER_BIT_W{1'b0}};
         recorded_ff <= 1'b0;
      end
      else
      begin
         // flags mark any error seen
         if (is_single)
            err_single_ff <= 1'b1;
         if (is_multi)
            err_multi_ff <= 1'b1;
         // only the first error's location is kept
         // the flags still follow later errors in repair mode
         if ((is_single || is_multi) && !recorded_ff)
         begin
            recorded_ff <= 1'b1;
            err_frame_ff <= ecc_frame;
            err_cluster_ff <= ecc_cluster;
            // dual error: offsets are zeroed and must be ignored
            err_block_ff <= is_multi ? {`CSER_BLK_W{1'b0}} : ecc_block;
            err_bit_ff <= is_multi ? {`CSER_BIT_W{1'b0}} : ecc_bit;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // error counters, saturating
   // they hold at all ones instead of wrapping, so a count never reads low
   // they move only while running, so mode off leaves them alone
   always @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         // power-up: both counts empty
         cnt_single_ff <= {`CSER_CNT_W{1'b0}};
         cnt_multi_ff <= {`CSER_CNT_W{1'b0}};
      end
      else if (clear_all)
      begin
         cnt_single_ff <= {`CSER_CNT_W{1'b0}};
         cnt_multi_ff <= {`CSER_CNT_W{1'b0}};
      end
      else
      begin
         if (is_single && ~&cnt_single_ff)
            cnt_single_ff <= cnt_single_ff + {{`CSER_CNT_W-1{1'b0}}, 1'b1};
         if (is_multi && ~&cnt_multi_ff)
            cnt_multi_ff <= cnt_multi_ff + {{`CSER_CNT_W-1{1'b0}}, 1'b1};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // control registers and sticky status; set wins over write-one clear
   assign set_bits = {crc_fail, is_multi, is_single};
   assign sts_wr = reg_wr & (reg_addr == `CSER_REG_STATUS);

   // per-bit sticky status: an event in the clear cycle keeps its bit set
   generate
      for (gi = 0; gi < `CSER_IRQ_W; gi = gi + 1)
      begin : g_sts
         assign nxt_sts[gi] = set_bits[gi] | (sts_ff[gi] & ~(sts_wr & reg_wdata[gi]));
      end
   endgenerate

   always @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         // software starts with scrubbing off and no bypass
         mode_ff <= `CSER_MODE_OFF;
         crc_bypass_ff <= 1'b0;
         mask_ff <= {`CSER_IRQ_W{1'b0}};
         sts_ff <= {`CSER_IRQ_W{1'b0}};
      end
      else
      begin
         if (reg_wr && reg_addr == `CSER_REG_CTRL)
         begin
            // mode and bypass take effect on the edge after the write
            mode_ff <= reg_wdata[`CSER_MODE_W-1:0];
            crc_bypass_ff <= reg_wdata[`CSER_CTRL_BYP];
         end
         if (reg_wr && reg_addr == `CSER_REG_MASK)
            mask_ff <= reg_wdata[`CSER_IRQ_W-1:0];
         // write-one clear, then new events set
         sts_ff <= nxt_sts;
      end
   end

   // a level: high until software clears or masks every set bit
   assign irq = |(sts_ff & mask_ff);

   ////////////////////////////////////////////////////////////////////////
   // read data, one cycle after the strobe; zero otherwise
   // unmapped offsets read zero; status also shows the state code
   always @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         reg_rdata_ff <= 32'h0;
      else if (reg_rd)
      begin
         case (reg_addr)
            `CSER_REG_CTRL:
               reg_rdata_ff <= {29'h0, crc_bypass_ff, mode_ff};
            `CSER_REG_STATUS:
               reg_rdata_ff <= {26'h0, st_ff, sts_ff};
            `CSER_REG_MASK:
               reg_rdata_ff <= {29'h0, mask_ff};
            `CSER_REG_FRAME:
               reg_rdata_ff <= {6'h0, err_multi_ff, err_single_ff, err_frame_ff};
            `CSER_REG_LOC:
               reg_rdata_ff <= {9'h0, err_bit_ff, err_block_ff, err_cluster_ff};
            // counts: multiple in the upper half, single in the lower
            `CSER_REG_COUNT:
               reg_rdata_ff <= {cnt_multi_ff, cnt_single_ff};
            default:
               reg_rdata_ff <= 32'h0;
         endcase
      end
      else
         reg_rdata_ff <= 32'h0;
   end

endmodule
`default_nettype wire
